/* File: rtl/sfr_regs.svh */
// Constants for the flag and status readout: frame fields, addresses, sizes
`ifndef SFR_REGS_SVH
`define SFR_REGS_SVH

// -----------------------------------------------------------------------
// Frame fields
// -----------------------------------------------------------------------
`define SFR_FRAME_BITS 16
`define SFR_SEL_HI 15
`define SFR_SEL_LO 14
`define SFR_ADDR_HI 13
`define SFR_ADDR_LO 9
`define SFR_FIXED_BIT 8
`define SFR_GROUP_BIT 7
`define SFR_SEL_FLAGS 2'h3
`define SFR_SEL_STATUS 2'h0

// -----------------------------------------------------------------------
// Register addresses
// -----------------------------------------------------------------------
`define SFR_ADDR_REG 5'h0f
`define SFR_ADDR_BUS 5'h10

// -----------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------
`define SFR_FLAGS_RESET 8'h00
`define SFR_FIXED_STATUS_DEF 8'h00
`endif

/* File: rtl/sfr_pkg.sv */
// Types for the flag and status readout
package sfr_pkg;
	// Events per group: regulator group 0/1, bus group 0/1
	typedef struct packed {
		logic [7:0] reg_grp0;
		logic [7:0] reg_grp1;
		logic [7:0] bus_grp0;
		logic [7:0] bus_grp1;
	} sfr_fault_t;

	typedef enum logic [2:0] {
		SFR_IDLE = 3'b001,
		SFR_SHIFT = 3'b010,
		SFR_DONE = 3'b100
	} sfr_state_t;
endpackage

/* File: rtl/sfr_readout.sv */
// SPI readout of latched failure flags and real-time status
`timescale 1ns/1ps
`include "sfr_regs.svh"

module sfr_readout
	import sfr_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// SPI, synchronous to clock_i; sclk rising edge samples MOSI
	input wire logic spi_cs_n_i,
	input wire logic spi_sclk_i,
	input wire logic spi_mosi_i,
	output logic spi_miso_o,
	// Fault events (set) and present conditions (still active)
	input wire sfr_fault_t fault_event_i,
	input wire sfr_fault_t fault_active_i,
	// Real-time bus interface state: driver, receiver, wake-up enable
	input wire logic [2:0] bus_state_i,
	// Fixed status byte
	input wire logic [7:0] fixed_status_i,
	// Latched flags, for observation
	output sfr_fault_t flags_o
);
	localparam int FB = `SFR_FRAME_BITS;

	initial begin
		if (FB != 16) $error("sfr_readout: frame must be 16 bits");
	end

	// -------------------------------------------------------------------
	// Frame state
	// -------------------------------------------------------------------
	sfr_state_t state_reg, state_next;
	logic [FB-1:0] rx_reg, rx_next;
	logic [FB-1:0] tx_reg, tx_next;
	logic [4:0] cnt_reg, cnt_next;
	logic sclk_reg, sclk_next;
	logic miso_reg, miso_next;
	sfr_fault_t flags_reg, flags_next;
	logic [7:0] sel_byte;
	logic [7:0] clr_mask;
	logic rise, fall;
	logic [8:0] hdr;
	logic [1:0] sel;
	logic [4:0] addr;
	logic grp;

	assign rise = spi_sclk_i & ~sclk_reg;
	assign fall = ~spi_sclk_i & sclk_reg;

	// -------------------------------------------------------------------
	// Header decode
	// -------------------------------------------------------------------
	// After eight rises rx_reg[7:0] holds frame bits 15..8, and the
	// group bit stands on MOSI at the ninth rise. Decoding from that,
	// rather than from rx_reg one clock later, lets the answer MSB reach
	// MISO before the master samples frame bit 7 at the end of that
	// high phase. Limitation: the master must sample MISO late in the
	// high phase, not right at the sclk rise.
	// Bit 8 and bits 6..0 are never looked at: no parity
	assign hdr = {rx_reg[7:0], spi_mosi_i};
	assign sel = hdr[8:7];
	assign addr = hdr[6:2];
	assign grp = hdr[0];

	// -------------------------------------------------------------------
	// Answer byte select
	// -------------------------------------------------------------------
	// Unmapped addresses and selectors 01 and 10 answer 0x00, so a
	// stray read never shows stale data from another group.
	// Flags are shown as latched at the ninth rise, before any clear; an event
	// set after that rise and before the clear cycle drops unseen unless still active.
	always_comb begin
		sel_byte = 8'h00;
		if (sel == `SFR_SEL_FLAGS) begin
			if (addr == `SFR_ADDR_REG) begin
				sel_byte = grp ? flags_reg.reg_grp1 : flags_reg.reg_grp0;
			end else if (addr == `SFR_ADDR_BUS) begin
				sel_byte = grp ? flags_reg.bus_grp1 : flags_reg.bus_grp0;
			end
		end else if (sel == `SFR_SEL_STATUS) begin
			if (addr == `SFR_ADDR_BUS && grp) begin
				sel_byte = {bus_state_i, 5'h00};
			end
		end
	end

	// -------------------------------------------------------------------
	// Shift engine and flag latches
	// -------------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		rx_next = rx_reg;
		tx_next = tx_reg;
		cnt_next = cnt_reg;
		miso_next = miso_reg;
		sclk_next = spi_sclk_i;
		clr_mask = 8'h00;
		// Set wins over a same-cycle clear
		flags_next = flags_reg | fault_event_i;
		case (state_reg)
			SFR_IDLE: begin
				if (!spi_cs_n_i) begin
					state_next = SFR_SHIFT;
					cnt_next = 5'h00;
					tx_next = {fixed_status_i, 8'h00};
					miso_next = fixed_status_i[7];
				end
			end
			SFR_SHIFT: begin
				if (spi_cs_n_i) begin
					state_next = SFR_IDLE;
				end else if (rise) begin
					rx_next = {rx_reg[FB-2:0], spi_mosi_i};
					cnt_next = cnt_reg + 5'h01;
					if (cnt_reg == 5'd8) begin
						// Ninth rise: header complete, the answer byte
						// takes bits 7..0 and its MSB goes out now
						tx_next = {sel_byte, 8'h00};
						miso_next = sel_byte[7];
					end
				end else if (fall) begin
					// Status bits first, then the answer byte
					tx_next = {tx_reg[FB-2:0], 1'b0};
					miso_next = tx_next[FB-1];
					if (cnt_reg == 5'd16) begin
						state_next = SFR_DONE;
					end
				end
			end
			SFR_DONE: begin
				// Clear only on a complete frame, so an aborted read
				// never loses a flag
				if (spi_cs_n_i) begin
					state_next = SFR_IDLE;
					if (rx_reg[`SFR_SEL_HI:`SFR_SEL_LO] == `SFR_SEL_FLAGS) begin
						clr_mask = 8'hff;
					end
				end
			end
			default: state_next = SFR_IDLE;
		endcase
		if (clr_mask != 8'h00) begin
			// Only recovered flags drop on read
			if (rx_reg[`SFR_ADDR_HI:`SFR_ADDR_LO] == `SFR_ADDR_REG) begin
				if (rx_reg[`SFR_GROUP_BIT]) begin
					flags_next.reg_grp1 = fault_event_i.reg_grp1 |
						(flags_reg.reg_grp1 & fault_active_i.reg_grp1);
				end else begin
					flags_next.reg_grp0 = fault_event_i.reg_grp0 |
						(flags_reg.reg_grp0 & fault_active_i.reg_grp0);
				end
			end else if (rx_reg[`SFR_ADDR_HI:`SFR_ADDR_LO] == `SFR_ADDR_BUS) begin
				if (rx_reg[`SFR_GROUP_BIT]) begin
					flags_next.bus_grp1 = fault_event_i.bus_grp1 |
						(flags_reg.bus_grp1 & fault_active_i.bus_grp1);
				end else begin
					flags_next.bus_grp0 = fault_event_i.bus_grp0 |
						(flags_reg.bus_grp0 & fault_active_i.bus_grp0);
				end
			end
		end
		if (state_next == SFR_IDLE) begin
			miso_next = 1'b0;
		end
	end

	// -------------------------------------------------------------------
	// Registers
	// -------------------------------------------------------------------
	// Every output leaves from a flip-flop, so MISO never glitches
	// while the header decode settles.
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= SFR_IDLE;
			rx_reg <= 16'h0000;
			tx_reg <= 16'h0000;
			cnt_reg <= 5'h00;
			sclk_reg <= 1'b0;
			miso_reg <= 1'b0;
			flags_reg <= '0;
		end else begin
			state_reg <= state_next;
			rx_reg <= rx_next;
			tx_reg <= tx_next;
			cnt_reg <= cnt_next;
			sclk_reg <= sclk_next;
			miso_reg <= miso_next;
			flags_reg <= flags_next;
		end
	end

	assign spi_miso_o = miso_reg;
	assign flags_o = flags_reg;

endmodule // sfr_readout

/* File: test/sfr_readout_props.sv */
// Port assertions for the flag and status readout
`timescale 1ns/1ps
module sfr_readout_props
	import sfr_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_sclk_i,
	input wire logic spi_mosi_i,
	input wire logic spi_miso_o,
	input wire sfr_fault_t fault_event_i,
	input wire sfr_fault_t fault_active_i,
	input wire logic [2:0] bus_state_i,
	input wire logic [7:0] fixed_status_i,
	input wire sfr_fault_t flags_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	a_flag_set: assert property (
		(flags_o & $past(fault_event_i)) == $past(fault_event_i))
		else $error("event did not set flag");
	a_flag_rise: assert property (
		(flags_o & ~$past(flags_o) & ~$past(fault_event_i)) == '0)
		else $error("flag set without event");
	a_clear_cs: assert property (
		($past(flags_o) & ~flags_o) != '0 |-> $past(spi_cs_n_i))
		else $error("flag cleared inside frame");
	a_active_keep: assert property (
		($past(flags_o) & $past(fault_active_i) & ~flags_o) == '0)
		else $error("active flag cleared");
	a_first_bit: assert property (
		$fell(spi_cs_n_i) |=> spi_miso_o == $past(fixed_status_i[7]))
		else $error("first bit wrong");
	a_miso_idle: assert property (
		spi_cs_n_i [*3] |-> !spi_miso_o)
		else $error("miso active while idle");
	a_cs_release: assert property (
		$rose(spi_cs_n_i) |-> ##2 !spi_miso_o)
		else $error("miso not released");
	a_miso_edge: assert property (
		$changed(spi_miso_o) |-> $past(spi_cs_n_i, 2) ||
		($past(spi_sclk_i, 2) != $past(spi_sclk_i)) || $past(spi_cs_n_i))
		else $error("miso moved off an sclk edge");
endmodule // sfr_readout_props

/* File: test/sfr_spi_master.sv */
// Microcontroller model: SPI master issuing read frames
`timescale 1ns/1ps
module sfr_spi_master (
	input wire logic clock_i,
	input wire logic miso_i,
	output logic cs_n_o,
	output logic sclk_o,
	output logic mosi_o
);
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		mosi_o = 1'b0;
	end
	// Mode 0, each sclk level held 2+ clocks as the readout needs
	task automatic xfer(input logic [15:0] cmd, output logic [15:0] rx);
		@(negedge clock_i) cs_n_o = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			mosi_o = cmd[i];
			repeat (3) @(negedge clock_i);
			sclk_o = 1'b1;
			repeat (2) @(negedge clock_i);
			// Sample late in the high phase, where bit 7 has settled
			rx[i] = miso_i;
			sclk_o = 1'b0;
		end
		repeat (3) @(negedge clock_i);
		cs_n_o = 1'b1;
		// Released data line must not keep its last value
		mosi_o = ~mosi_o;
		repeat (3) @(negedge clock_i);
	endtask
endmodule // sfr_spi_master

/* File: test/tb_sfr_readout.sv */
// Testbench for the flag and status readout
`timescale 1ns/1ps
module tb_sfr_readout;
	import sfr_pkg::*;
	logic clock_i, rst_n_i, spi_cs_n_i, spi_sclk_i, spi_mosi_i, spi_miso_o;
	sfr_fault_t fault_event_i, fault_active_i, flags_o;
	logic [2:0] bus_state_i;
	logic [7:0] fixed_status_i;
	logic [15:0] rx;
	int err_total, cmp_count;
	logic [15:0] cmd [7] = '{16'hdf00, 16'hde00, 16'hdf80, 16'h5f00,
		16'he100, 16'he180, 16'h2180};
	logic [7:0] lo [7] = '{8'ha5, 8'h05, 8'h3c, 8'h00, 8'h81, 8'h42, 8'ha0};
	logic [31:0] fl [7] = '{32'h053c8142, 32'h053c8142, 32'h05008142,
		32'h05008142, 32'h05000042, 32'h05000000, 32'h05000000};
	sfr_readout sfr_readout_inst (.clock_i, .rst_n_i, .spi_cs_n_i,
		.spi_sclk_i, .spi_mosi_i, .spi_miso_o, .fault_event_i,
		.fault_active_i, .bus_state_i, .fixed_status_i, .flags_o);
	sfr_spi_master sfr_spi_master_inst (.clock_i, .miso_i(spi_miso_o),
		.cs_n_o(spi_cs_n_i), .sclk_o(spi_sclk_i), .mosi_o(spi_mosi_i));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic results;
		$display("errors %0d checks %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end
	initial begin
		rst_n_i = 1'b0;
		fault_event_i = '0;
		fault_active_i = 32'h05000000;
		bus_state_i = 3'h5;
		fixed_status_i = 8'h96;
		repeat (2) @(negedge clock_i);
		rst_n_i = 1'b1;
		@(negedge clock_i) chk(flags_o, '0);
		fault_event_i = 32'ha53c8142;
		@(negedge clock_i) fault_event_i = '0;
		@(negedge clock_i) chk(flags_o, 32'ha53c8142);
		for (int i = 0; i < 7; i++) begin
			sfr_spi_master_inst.xfer(cmd[i], rx);
			chk({16'h0, rx}, {16'h0, 8'h96, lo[i]});
			chk(flags_o, fl[i]);
		end
		results();
	end
endmodule // tb_sfr_readout
bind sfr_readout sfr_readout_props sfr_readout_props_inst (.clock_i,
	.rst_n_i, .spi_cs_n_i, .spi_sclk_i, .spi_mosi_i, .spi_miso_o,
	.fault_event_i, .fault_active_i, .bus_state_i, .fixed_status_i,
	.flags_o);
